// >>> pkg/tcr_pkg.sv
package tcr_pkg;

    // bus geometry: one aligned 32-bit word per nibble register
    localparam int unsigned ADDR_W     = 18;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned NIB_W      = 4;
    localparam int unsigned CNT_W      = 8;

    // register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_T2_CNT_LOW   = 16'hffd0;
    localparam logic [15:0] IDX_T2_CNT_HIGH  = 16'hffd1;
    localparam logic [15:0] IDX_T0_CMP_LOW   = 16'hffd2;
    localparam logic [15:0] IDX_T0_CMP_HIGH  = 16'hffd3;
    localparam logic [15:0] IDX_T1_CMP_LOW   = 16'hffd4;
    localparam logic [15:0] IDX_T1_CMP_HIGH  = 16'hffd5;
    localparam logic [15:0] IDX_PWM_SEL      = 16'hffd8;
    localparam logic [15:0] IDX_CMP_IRQ_EN   = 16'hffe0;
    localparam logic [15:0] IDX_UF_IRQ_EN    = 16'hffe1;
    localparam logic [15:0] IDX_CMP_FLAGS    = 16'hfff0;
    localparam logic [15:0] IDX_UF_FLAGS     = 16'hfff1;

    // implemented bits inside each control nibble
    localparam logic [3:0]  MASK_TWO_TIMERS   = 4'h3;
    localparam logic [3:0]  MASK_THREE_TIMERS = 4'h7;

    // values after initial reset
    localparam logic [3:0]  RST_NIBBLE = 4'h0;
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [1:0]  RST_TWO    = 2'h0;
    localparam logic [2:0]  RST_THREE  = 3'h0;

    // cycles from request edge to the edge where waitrequest is low
    localparam int unsigned BUS_LATENCY = 1;

    // per-cycle view of the counting core
    typedef struct packed {
        logic [7:0] timer0_count;       // timer 0 down-counter value
        logic [7:0] timer1_count;       // timer 1 down-counter value
        logic [7:0] timer2_count_value; // timer 2 down-counter value
        logic [2:0] underflow;          // one-cycle underflow pulses, bit n = timer n
        logic       cascade_mode_select; // timers 0 and 1 form one 16-bit timer
    } tcr_core_s;

endpackage

// >>> rtl/tcr_top.sv
// Functional notes
// - Timer 2 count high nibble is readable, starts at zero, and ignores writes.
// - Timer 0 compare value is eight read/write bits split low then high nibble, reset zero.
// - Timer 1 compare value is eight read/write bits split low then high nibble, reset zero.
// - Bits 0 and 1 of the output select nibble pick PWM (1) or normal (0) for timers 0 and 1.
// - Bits 0 and 1 of the compare enable nibble unmask the timer 0 and 1 match interrupts.
// - Bits 0 to 2 of the underflow enable nibble unmask the timer 0 to 2 underflow interrupts.
// - Match flags for timers 0 and 1 set on a match, clear on a written one, hold on zero.
// - Underflow flags for timers 0 to 2 set on underflow, clear on a written one, hold on zero.
// - Unimplemented bits of the select, enable and flag nibbles read zero and ignore writes.
// - Every implemented field is zero after the initial reset.
// - In PWM mode the compare value is checked against the count and arriving at equality is a match.
// - PWM output is built from underflow and match; normal output toggles on underflow alone.
// - While timers 0 and 1 are cascaded the timer 1 PWM select bit is ignored.
// - Reading the count low nibble freezes the high nibble, so read low before high.
`timescale 1ns/1ps
`default_nettype none

module tcr_top (
    input  wire logic                          i_clk,                 // 200 MHz clock
    input  wire logic                          i_reset,               // async reset, high
    // avalon-mm slave
    input  wire logic [tcr_pkg::ADDR_W-1:0]    i_avs_address,         // byte address
    input  wire logic                          i_avs_read,            // read request
    input  wire logic                          i_avs_write,           // write request
    input  wire logic [tcr_pkg::DATA_W-1:0]    i_avs_writedata,       // write data
    input  wire logic [3:0]                    i_avs_byteenable,      // byte lanes
    output logic [tcr_pkg::DATA_W-1:0]         o_avs_readdata,        // read data, registered
    output logic                               o_avs_waitrequest,     // stall
    // counting core
    input  wire tcr_pkg::tcr_core_s            i_core,                // counts and underflows
    // outputs
    output logic [1:0]                         o_timer_out,           // timer 0/1 waveform
    output logic [1:0]                         o_compare_match,       // match pulses
    output logic                               o_irq                  // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // index match for a printed register offset
    function automatic logic idx_hit(input logic [15:0] idx,
                                     input logic [tcr_pkg::ADDR_W-1:0] addr);
        idx_hit = (addr[tcr_pkg::ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    // write-one-to-clear with set winning over clear
    function automatic logic [2:0] flag_update(input logic [2:0] cur,
                                               input logic [2:0] set,
                                               input logic [2:0] clr);
        flag_update = (cur & ~clr) | set;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake

    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    wire         req     = i_avs_read | i_avs_write;
    // one wait cycle: data and writes land on the edge where waitrequest is low
    assign ack_next          = req & ~ack_reg;
    assign o_avs_waitrequest = req & ~ack_reg;
    wire         wr_fire = i_avs_write & ack_reg;
    wire         rd_fire = i_avs_read & ack_reg;
    wire         lane0   = i_avs_byteenable[0];
    wire [3:0]   wnib    = i_avs_writedata[3:0];

    // address decode
    wire hit_cnt_lo  = idx_hit(tcr_pkg::IDX_T2_CNT_LOW, i_avs_address);
    wire hit_cnt_hi  = idx_hit(tcr_pkg::IDX_T2_CNT_HIGH, i_avs_address);
    wire hit_t0_lo   = idx_hit(tcr_pkg::IDX_T0_CMP_LOW, i_avs_address);
    wire hit_t0_hi   = idx_hit(tcr_pkg::IDX_T0_CMP_HIGH, i_avs_address);
    wire hit_t1_lo   = idx_hit(tcr_pkg::IDX_T1_CMP_LOW, i_avs_address);
    wire hit_t1_hi   = idx_hit(tcr_pkg::IDX_T1_CMP_HIGH, i_avs_address);
    wire hit_pwm     = idx_hit(tcr_pkg::IDX_PWM_SEL, i_avs_address);
    wire hit_cmp_en  = idx_hit(tcr_pkg::IDX_CMP_IRQ_EN, i_avs_address);
    wire hit_uf_en   = idx_hit(tcr_pkg::IDX_UF_IRQ_EN, i_avs_address);
    wire hit_cmp_fl  = idx_hit(tcr_pkg::IDX_CMP_FLAGS, i_avs_address);
    wire hit_uf_fl   = idx_hit(tcr_pkg::IDX_UF_FLAGS, i_avs_address);

    // nibble write strobes; count nibbles have none, so writes there are dropped
    wire we_t0_lo  = wr_fire & lane0 & hit_t0_lo;
    wire we_t0_hi  = wr_fire & lane0 & hit_t0_hi;
    wire we_t1_lo  = wr_fire & lane0 & hit_t1_lo;
    wire we_t1_hi  = wr_fire & lane0 & hit_t1_hi;
    wire we_pwm    = wr_fire & lane0 & hit_pwm;
    wire we_cmp_en = wr_fire & lane0 & hit_cmp_en;
    wire we_uf_en  = wr_fire & lane0 & hit_uf_en;
    wire we_cmp_fl = wr_fire & lane0 & hit_cmp_fl;
    wire we_uf_fl  = wr_fire & lane0 & hit_uf_fl;

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    logic [7:0] t0_cmp_reg;
    logic [7:0] t0_cmp_next;
    logic [7:0] t1_cmp_reg;
    logic [7:0] t1_cmp_next;
    logic [1:0] pwm_sel_reg;
    logic [1:0] pwm_sel_next;
    logic [1:0] cmp_en_reg;
    logic [1:0] cmp_en_next;
    logic [2:0] uf_en_reg;
    logic [2:0] uf_en_next;

    // compare values, nibble at a time
    assign t0_cmp_next = {we_t0_hi ? wnib : t0_cmp_reg[7:4],
                          we_t0_lo ? wnib : t0_cmp_reg[3:0]};
    assign t1_cmp_next = {we_t1_hi ? wnib : t1_cmp_reg[7:4],
                          we_t1_lo ? wnib : t1_cmp_reg[3:0]};
    // only implemented bits are kept; upper bits of the nibble are dropped
    assign pwm_sel_next = we_pwm ? wnib[1:0] : pwm_sel_reg;
    assign cmp_en_next  = we_cmp_en ? wnib[1:0] : cmp_en_reg;
    assign uf_en_next   = we_uf_en ? wnib[2:0] : uf_en_reg;

    ////////////////////////////////////////////////////////////////////////////
    // count latch

    logic [3:0] cnt_hi_reg;
    logic [3:0] cnt_hi_next;
    // high nibble is caught as the low read completes, one edge after the low nibble is sampled
    assign cnt_hi_next = (rd_fire & hit_cnt_lo) ? i_core.timer2_count_value[7:4]
                                                : cnt_hi_reg;

    ////////////////////////////////////////////////////////////////////////////
    // compare match and waveform

    logic [1:0] eq_prev_reg;
    logic [1:0] wave_reg;
    logic [1:0] wave_next;
    logic [1:0] match_reg;
    wire        cascade   = i_core.cascade_mode_select;
    // timer 1 select has no meaning once it is the upper byte of timer 0
    wire [1:0]  pwm_eff   = {pwm_sel_reg[1] & ~cascade, pwm_sel_reg[0]};
    wire [1:0]  eq_now    = {i_core.timer1_count == t1_cmp_reg,
                             i_core.timer0_count == t0_cmp_reg};
    // one pulse per arrival at the compare value, not one per cycle it sits there
    wire [1:0]  match_evt = pwm_eff & eq_now & ~eq_prev_reg;

    // pwm: high from reload, low at match; normal: toggle on underflow
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            if (pwm_eff[n]) begin
                if (i_core.underflow[n]) begin
                    wave_next[n] = 1'b1;
                end else if (match_evt[n]) begin
                    wave_next[n] = 1'b0;
                end else begin
                    wave_next[n] = wave_reg[n];
                end
            end else begin
                wave_next[n] = wave_reg[n] ^ i_core.underflow[n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt flags

    logic [1:0] cmp_fl_reg;
    logic [1:0] cmp_fl_next;
    logic [2:0] uf_fl_reg;
    logic [2:0] uf_fl_next;
    wire  [2:0] cmp_clr = we_cmp_fl ? {1'b0, wnib[1:0]} : 3'h0;
    wire  [2:0] uf_clr  = we_uf_fl ? wnib[2:0] : 3'h0;
    wire  [2:0] cmp_upd = flag_update({1'b0, cmp_fl_reg}, {1'b0, match_evt}, cmp_clr);
    // flags set whatever their enables say
    assign cmp_fl_next = cmp_upd[1:0];
    assign uf_fl_next  = flag_update(uf_fl_reg, i_core.underflow, uf_clr);
    assign o_irq = |(cmp_fl_reg & cmp_en_reg) | |(uf_fl_reg & uf_en_reg);

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped and unimplemented bits read zero

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (rd_fire) begin
            rdata_next = rdata_reg;
        end else if (i_avs_read & ~ack_reg) begin
            unique case (1'b1)
                hit_cnt_lo: rdata_next[3:0] = i_core.timer2_count_value[3:0];
                hit_cnt_hi: rdata_next[3:0] = cnt_hi_reg;
                hit_t0_lo:  rdata_next[3:0] = t0_cmp_reg[3:0];
                hit_t0_hi:  rdata_next[3:0] = t0_cmp_reg[7:4];
                hit_t1_lo:  rdata_next[3:0] = t1_cmp_reg[3:0];
                hit_t1_hi:  rdata_next[3:0] = t1_cmp_reg[7:4];
                hit_pwm:    rdata_next[1:0] = pwm_sel_reg;
                hit_cmp_en: rdata_next[1:0] = cmp_en_reg;
                hit_uf_en:  rdata_next[2:0] = uf_en_reg;
                hit_cmp_fl: rdata_next[1:0] = cmp_fl_reg;
                hit_uf_fl:  rdata_next[2:0] = uf_fl_reg;
                default:    rdata_next = 32'h0000_0000;
            endcase
        end
    end
    assign o_avs_readdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // state

    // bus and data registers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ack_reg     <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            t0_cmp_reg  <= tcr_pkg::RST_BYTE;
            t1_cmp_reg  <= tcr_pkg::RST_BYTE;
            pwm_sel_reg <= tcr_pkg::RST_TWO;
            cmp_en_reg  <= tcr_pkg::RST_TWO;
            uf_en_reg   <= tcr_pkg::RST_THREE;
            cnt_hi_reg  <= tcr_pkg::RST_NIBBLE;
        end else begin
            ack_reg     <= ack_next;
            rdata_reg   <= rdata_next;
            t0_cmp_reg  <= t0_cmp_next;
            t1_cmp_reg  <= t1_cmp_next;
            pwm_sel_reg <= pwm_sel_next;
            cmp_en_reg  <= cmp_en_next;
            uf_en_reg   <= uf_en_next;
            cnt_hi_reg  <= cnt_hi_next;
        end
    end

    // event side
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            eq_prev_reg <= tcr_pkg::RST_TWO;
            wave_reg    <= tcr_pkg::RST_TWO;
            match_reg   <= tcr_pkg::RST_TWO;
            cmp_fl_reg  <= tcr_pkg::RST_TWO;
            uf_fl_reg   <= tcr_pkg::RST_THREE;
        end else begin
            eq_prev_reg <= eq_now;
            wave_reg    <= wave_next;
            match_reg   <= match_evt;
            cmp_fl_reg  <= cmp_fl_next;
            uf_fl_reg   <= uf_fl_next;
        end
    end

    assign o_timer_out     = wave_reg;
    assign o_compare_match = match_reg;

endmodule

`default_nettype wire

// >>> tb/tcr_properties.sv
`timescale 1ns/1ps
`default_nettype none

module tcr_properties (
    input wire logic                       i_clk,             // clock
    input wire logic                       i_reset,           // async reset
    input wire logic [tcr_pkg::ADDR_W-1:0] i_avs_address,     // byte address
    input wire logic                       i_avs_read,        // read request
    input wire logic                       i_avs_write,       // write request
    input wire logic [tcr_pkg::DATA_W-1:0] i_avs_writedata,   // write data
    input wire logic [3:0]                 i_avs_byteenable,  // byte lanes
    input wire logic [tcr_pkg::DATA_W-1:0] o_avs_readdata,    // read data
    input wire logic                       o_avs_waitrequest, // stall
    input wire tcr_pkg::tcr_core_s         i_core,            // core view
    input wire logic [1:0]                 o_timer_out,       // waveforms
    input wire logic [1:0]                 o_compare_match,   // match pulses
    input wire logic                       o_irq              // interrupt
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // any request, read or write
    wire logic req = i_avs_read | i_avs_write;

    // bus handshake: exactly one wait cycle, none while idle
    a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
        else $error("no wait cycle on new request");
    a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("wait longer than one cycle");
    a_idle_free: assert property (!req |-> !o_avs_waitrequest)
        else $error("waitrequest while idle");
    a_read_upper: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:4] == '0)
        else $error("read data upper bits set");
    // match is an edge event, never two cycles in a row
    a_match_single: assert property (o_compare_match[0] |=> !o_compare_match[0])
        else $error("match pulse too long");
    // interrupt moves only for an event or a bus write
    a_irq_rise: assert property ($rose(o_irq) |-> $past(i_core.underflow) != 3'h0
        || o_compare_match != 2'h0 || $past(o_compare_match) != 2'h0 || $past(i_avs_write))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(o_irq) |-> $past(i_avs_write))
        else $error("irq fell without write");
    // a waveform can only rise on its underflow
    a_wave_rise: assert property ($rose(o_timer_out[0]) |-> $past(i_core.underflow[0]))
        else $error("timer 0 output rose without underflow");

    c_irq: cover property ($rose(o_irq));
    c_match: cover property (o_compare_match[0]);
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule

`default_nettype wire

// >>> tb/timer_compare_irq_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module timer_compare_irq_regs_tb;
    typedef struct {logic [15:0] idx; logic [3:0] wd; logic [3:0] ex;} tcr_row_s;
    logic                       i_clk = 1'b0;
    logic                       i_reset = 1'b1;
    logic [tcr_pkg::ADDR_W-1:0] i_avs_address = '0;
    logic                       i_avs_read = 1'b0;
    logic                       i_avs_write = 1'b0;
    logic [tcr_pkg::DATA_W-1:0] i_avs_writedata = '0;
    logic [3:0]                 i_avs_byteenable = 4'h1;
    tcr_pkg::tcr_core_s         i_core = '0;
    logic [tcr_pkg::DATA_W-1:0] o_avs_readdata;
    logic                       o_avs_waitrequest;
    logic [1:0]                 o_timer_out;
    logic [1:0]                 o_compare_match;
    logic                       o_irq;
    int                         err_total = 0;
    int                         n_compared = 0;
    logic [3:0]                 q;
    logic                       v;
    // write value and readback; unimplemented bits, read-only and unmapped places included
    tcr_row_s rows [10] = '{'{16'hffd2, 4'h5, 4'h5}, '{16'hffd3, 4'ha, 4'ha},
        '{16'hffd4, 4'hc, 4'hc}, '{16'hffd5, 4'h3, 4'h3}, '{16'hffd8, 4'hf, 4'h3},
        '{16'hffe0, 4'hf, 4'h3}, '{16'hffe1, 4'hf, 4'h7}, '{16'hffd1, 4'hf, 4'h0},
        '{16'hffe8, 4'hf, 4'h0}, '{16'hfff0, 4'hf, 4'h0}};

    always #2.5 i_clk = ~i_clk;

    tcr_top dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_core(i_core), .o_timer_out(o_timer_out),
        .o_compare_match(o_compare_match), .o_irq(o_irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [3:0] got, input logic [3:0] ex);
        n_compared++;
        if (got !== ex) begin
            err_total++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, ex);
        end
    endtask

    // one avalon transfer; request held until the edge that samples waitrequest low,
    // readdata taken at that very edge, released only after it
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [3:0] d);
        int n;
        n = 0;
        i_avs_address <= {idx, 2'b00};
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        i_avs_writedata <= {28'h000_0000, d};
        @(posedge i_clk);
        while (o_avs_waitrequest && n < 20) begin
            n++;
            @(posedge i_clk);
        end
        if (n == 20) begin
            err_total++;
            $display("[ERR] t=%0t bus answer timed out", $time);
        end
        q = o_avs_readdata[3:0];
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        // idle edge so the next request never reassigns in the same step
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [3:0] ex);
        bus(1'b0, idx, 4'h0);
        chk(q, ex);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #(4000 * 5);
        err_total++;
        $display("[ERR] t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        tick(3);
        i_reset <= 1'b0;
        tick(1);
        foreach (rows[i]) rd(rows[i].idx, 4'h0);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].idx, rows[i].wd);
            rd(rows[i].idx, rows[i].ex);
        end
        $display("register table done");
        // all underflows at once, pwm selected on timers 0 and 1
        i_core.underflow <= 3'h7;
        tick(1);
        i_core.underflow <= 3'h0;
        tick(1);
        chk({3'h0, o_irq}, 4'h1);
        chk({2'h0, o_timer_out}, 4'h3);
        rd(16'hfff1, 4'h7);
        bus(1'b1, 16'hfff1, 4'h9);
        rd(16'hfff1, 4'h6);
        bus(1'b1, 16'hffe1, 4'h0);
        chk({3'h0, o_irq}, 4'h0);
        bus(1'b1, 16'hfff1, 4'h6);
        rd(16'hfff1, 4'h0);
        $display("underflow flags done");
        // low read freezes the high nibble
        i_core.timer2_count_value <= 8'ha5;
        rd(16'hffd0, 4'h5);
        i_core.timer2_count_value <= 8'h3c;
        bus(1'b1, 16'hffd1, 4'hf);
        rd(16'hffd1, 4'ha);
        $display("count freeze done");
        // both counts hit their compare values, timer 1 cascaded away
        i_core.timer0_count <= 8'ha5;
        i_core.timer1_count <= 8'h3c;
        i_core.cascade_mode_select <= 1'b1;
        tick(3);
        rd(16'hfff0, 4'h1);
        chk({3'h0, o_irq}, 4'h1);
        chk({3'h0, o_timer_out[0]}, 4'h0);
        i_core.timer1_count <= 8'h00;
        i_core.cascade_mode_select <= 1'b0;
        tick(1);
        i_core.timer1_count <= 8'h3c;
        tick(2);
        chk({2'h0, o_compare_match}, 4'h2);
        tick(1);
        rd(16'hfff0, 4'h3);
        bus(1'b1, 16'hfff0, 4'h3);
        rd(16'hfff0, 4'h0);
        $display("compare match done");
        // normal output toggles on underflow alone
        bus(1'b1, 16'hffd8, 4'h0);
        v = o_timer_out[0];
        i_core.underflow <= 3'h1;
        tick(1);
        i_core.underflow <= 3'h0;
        tick(1);
        chk({3'h0, o_timer_out[0]}, {3'h0, ~v});
        // lane 0 disabled write is dropped, then a mid-run reset
        i_avs_byteenable <= 4'h0;
        bus(1'b1, 16'hffd2, 4'h0);
        i_avs_byteenable <= 4'h1;
        rd(16'hffd2, 4'h5);
        i_reset <= 1'b1;
        tick(1);
        i_reset <= 1'b0;
        tick(1);
        rd(16'hffd2, 4'h0);
        $display("awkward cases done");
        end_of_test();
    end
endmodule

bind tcr_top tcr_properties chk_u (.i_clk(i_clk), .i_reset(i_reset),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_core(i_core),
    .o_timer_out(o_timer_out), .o_compare_match(o_compare_match), .o_irq(o_irq));

`default_nettype wire
